//--- flash_erase_write_control.sv
`timescale 1ns/1ps

// Function
// - Mass erase starts on key 0xaa only after mass-erase enable was set.
// - Mass erase is refused unless the emulation port is enabled.
// - Page erase starts on key 0x55 using the page number in bits 7 to 1.
// - Only exact keys in proper order trigger erasure; stray writes never erase.
// - Program-write enable steers external stores to flash while no erase runs, otherwise to RAM.
// - An erased flash byte reads as 0xff.
// - Cells are not erased singly; pages are copied, erased and rewritten.
// - A flash write also writes the RAM cell aliased at that address.
// - A configuration bit selects the flash access pulse width.
module flash_erase_write_control
#(
	parameter int ADDR_W = 16,
	parameter int PAGE_W = 7,
	parameter int TMR_W  = 16
) (
	// Clock and reset.
	input  wire logic                 core_clk_i,
	input  wire logic                 resetn_i,
	// Special function register port.
	input  wire logic                 sfr_wr_i,
	input  wire logic                 sfr_rd_i,
	input  wire logic [7:0]           sfr_addr_i,
	input  wire logic [7:0]           sfr_wdata_i,
	output logic      [7:0]           sfr_rdata_o,
	// Emulation port status.
	input  wire logic                 ice_enable_i,
	// External data store from the processor.
	input  wire logic                 xstore_i,
	input  wire logic [ADDR_W-1:0]    xstore_addr_i,
	input  wire logic [7:0]           xstore_data_i,
	// Flash array control.
	output logic                      flash_wr_o,
	output logic [ADDR_W-1:0]         flash_addr_o,
	output logic [7:0]                flash_wdata_o,
	output logic                      page_erase_o,
	output logic                      mass_erase_o,
	output logic [PAGE_W-1:0]         erase_page_o,
	output logic                      erase_busy_o,
	output logic                      flash_pulse_width_sel_o,
	input  wire logic [7:0]           flash_array_rdata_i,
	input  wire logic                 flash_array_erased_i,
	output logic [7:0]                flash_rdata_o,
	// External RAM control.
	output logic                      ram_wr_o,
	output logic [ADDR_W-1:0]         ram_addr_o,
	output logic [7:0]                ram_wdata_o
);

	import flash_ctl_pkg::*;

	// Register state, sequencer state and the timer handshake.
	logic [7:0]       flash_write_control_r;
	logic [7:0]       erase_page_select_r;
	erase_state_t     state_r;
	logic             timer_load;
	logic [TMR_W-1:0] timer_count;
	logic             timer_busy;
	logic             timer_done;
	logic             trig_wr;
	logic             mass_go;
	logic             page_go;
	logic             flash_target;

	// Decoded key writes to the erase trigger.
	// A key is honoured only in idle, so a second key during an erase is dropped.
	assign trig_wr = sfr_wr_i && (sfr_addr_i == ERASE_TRIGGER_ADDR);
	assign mass_go = trig_wr && (sfr_wdata_i == MASS_ERASE_KEY)
		&& flash_write_control_r[MASS_ERASE_ENABLE_BIT]
		&& ice_enable_i && (state_r == ERASE_IDLE);
	assign page_go = trig_wr && (sfr_wdata_i == PAGE_ERASE_KEY)
		&& (state_r == ERASE_IDLE);

	// Control register; the mass-erase enable is spent once a mass erase is launched.
	// The write and the self-clear name different addresses, so they never collide.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			flash_write_control_r <= FLASH_WRITE_CONTROL_RST;
		else if (sfr_wr_i && (sfr_addr_i == FLASH_WRITE_CONTROL_ADDR))
			flash_write_control_r <= sfr_wdata_i & 8'h07;
		else if (mass_go)
			flash_write_control_r[MASS_ERASE_ENABLE_BIT] <= 1'b0;
	end

	// Page select register.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			erase_page_select_r <= ERASE_PAGE_SELECT_RST;
		else if (sfr_wr_i && (sfr_addr_i == ERASE_PAGE_SELECT_ADDR))
			erase_page_select_r <= {sfr_wdata_i[PAGE_MSB:PAGE_LSB], 1'b0};
	end

	// Erase sequencer: idle, page erase or mass erase until the timer ends.
	// The state outlasts the timer by one cycle, so busy never drops early.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			state_r <= ERASE_IDLE;
		else
		begin
			case (state_r)
				ERASE_IDLE:
				begin
					if (mass_go)
						state_r <= ERASE_MASS;
					else if (page_go)
						state_r <= ERASE_PAGE;
				end
				ERASE_PAGE, ERASE_MASS:
				begin
					if (timer_done)
						state_r <= ERASE_IDLE;
				end
				default:
					state_r <= ERASE_IDLE;
			endcase
		end
	end

	// Timer loading for the selected erase.
	// The two keys differ, so at most one of the launch terms is true.
	assign timer_load  = mass_go || page_go;
	assign timer_count = mass_go ? TMR_W'(MASS_ERASE_CYCLES) : TMR_W'(PAGE_ERASE_CYCLES);

	erase_timer #(
		.WIDTH (TMR_W)
	) u_erase_timer (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.load_i     (timer_load),
		.count_i    (timer_count),
		.busy_o     (timer_busy),
		.done_o     (timer_done)
	);

	// Erase strobes held during the active interval.
	assign mass_erase_o = (state_r == ERASE_MASS);
	assign page_erase_o = (state_r == ERASE_PAGE);
	assign erase_page_o = erase_page_select_r[PAGE_MSB:PAGE_LSB];
	assign erase_busy_o = timer_busy || (state_r != ERASE_IDLE);
	assign flash_pulse_width_sel_o = flash_write_control_r[FLASH_PULSE_WIDTH_SEL_BIT];

	// Flash is the store target while program-write enable is set and no erase runs.
	// A store during an erase goes to RAM; a store in the cycle of the launching key still reaches flash in the first erase cycle.
	assign flash_target = flash_write_control_r[PROGRAM_WRITE_ENABLE_BIT]
		&& (state_r == ERASE_IDLE);

	// Store steering registered toward the flash and RAM arrays.
	// Address and data load only on a store, so they hold the last store between pulses.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			flash_wr_o    <= 1'b0;
			ram_wr_o      <= 1'b0;
			flash_addr_o  <= '0;
			flash_wdata_o <= 8'h00;
			ram_addr_o    <= '0;
			ram_wdata_o   <= 8'h00;
		end
		else
		begin
			flash_wr_o <= xstore_i && flash_target;
			// A flash write also lands in any RAM cell at that address.
			ram_wr_o   <= xstore_i && (!flash_target || ram_alias(xstore_addr_i));
			if (xstore_i)
			begin
				flash_addr_o  <= xstore_addr_i;
				flash_wdata_o <= xstore_data_i;
				ram_addr_o    <= xstore_addr_i;
				ram_wdata_o   <= xstore_data_i;
			end
		end
	end

	// True where an on-chip RAM is mapped under the flash address.
	// Addresses outside every window write the flash alone.
	function automatic logic ram_alias(input logic [ADDR_W-1:0] a);
		logic [15:0] w;
		w = 16'(a);
		ram_alias = (w <= MPU_RAM_HI)
			|| (w >= CE_DRAM_LO && w <= CE_DRAM_HI)
			|| (w >= IO_RAM_LO && w <= IO_RAM_HI)
			|| (w >= CE_PRAM_LO && w <= CE_PRAM_HI);
	endfunction

	// Read data of the flash array; erased bytes return all ones.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			flash_rdata_o <= ERASED_BYTE;
		else
			flash_rdata_o <= flash_array_erased_i ? ERASED_BYTE : flash_array_rdata_i;
	end

	// Register read data; the trigger is write only and reads zero.
	// Read data holds until the next read strobe.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			sfr_rdata_o <= 8'h00;
		else if (sfr_rd_i)
		begin
			case (sfr_addr_i)
				FLASH_WRITE_CONTROL_ADDR: sfr_rdata_o <= flash_write_control_r;
				ERASE_PAGE_SELECT_ADDR:   sfr_rdata_o <= erase_page_select_r;
				default:                  sfr_rdata_o <= 8'h00;
			endcase
		end
	end

endmodule

//--- flash_ctl_pkg.sv
package flash_ctl_pkg;

	// Register offsets on the special function register bus.
	localparam logic [7:0] ERASE_TRIGGER_ADDR       = 8'h94;
	localparam logic [7:0] FLASH_WRITE_CONTROL_ADDR = 8'hb2;
	localparam logic [7:0] ERASE_PAGE_SELECT_ADDR   = 8'hb7;

	// Field positions in the write control register.
	localparam int PROGRAM_WRITE_ENABLE_BIT  = 0;
	localparam int MASS_ERASE_ENABLE_BIT     = 1;
	localparam int FLASH_PULSE_WIDTH_SEL_BIT = 2;

	// Page number field of the page select register.
	localparam int PAGE_LSB = 1;
	localparam int PAGE_MSB = 7;

	// Key patterns and the erased byte value.
	localparam logic [7:0] MASS_ERASE_KEY = 8'haa;
	localparam logic [7:0] PAGE_ERASE_KEY = 8'h55;
	localparam logic [7:0] ERASED_BYTE    = 8'hff;

	// Reset values.
	localparam logic [7:0] FLASH_WRITE_CONTROL_RST = 8'h00;
	localparam logic [7:0] ERASE_PAGE_SELECT_RST   = 8'h00;

	// Erase busy times in cycles of the 20 MHz clock.
	localparam int CLK_MHZ          = 20;
	localparam int PAGE_ERASE_US    = 20;
	localparam int MASS_ERASE_US    = 200;
	localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_US * CLK_MHZ;
	localparam int MASS_ERASE_CYCLES = MASS_ERASE_US * CLK_MHZ;

	// Address windows of memories aliased by a flash write.
	localparam logic [15:0] MPU_RAM_LO  = 16'h0000;
	localparam logic [15:0] MPU_RAM_HI  = 16'h07ff;
	localparam logic [15:0] CE_DRAM_LO  = 16'h1000;
	localparam logic [15:0] CE_DRAM_HI  = 16'h13ff;
	localparam logic [15:0] IO_RAM_LO   = 16'h2000;
	localparam logic [15:0] IO_RAM_HI   = 16'h20ff;
	localparam logic [15:0] CE_PRAM_LO  = 16'h3000;
	localparam logic [15:0] CE_PRAM_HI  = 16'h3fff;

	typedef enum logic [1:0] {
		ERASE_IDLE,
		ERASE_PAGE,
		ERASE_MASS
	} erase_state_t;

endpackage

//--- erase_timer.sv
`timescale 1ns/1ps

// Counts down an erase busy interval and pulses done at its end.
module erase_timer #(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input  wire logic             core_clk_i,
	input  wire logic             resetn_i,
	// Load and status.
	input  wire logic             load_i,
	input  wire logic [WIDTH-1:0] count_i,
	output logic                  busy_o,
	output logic                  done_o
);

	logic [WIDTH-1:0] count_r;

	// Loads the interval and counts it down to zero.
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			count_r <= '0;
			done_o  <= 1'b0;
		end
		else
		begin
			done_o <= (count_r == {{(WIDTH-1){1'b0}}, 1'b1}) && !load_i;
			if (load_i)
				count_r <= count_i;
			else if (count_r != '0)
				count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign busy_o = (count_r != '0);

endmodule

//--- erase_ctl_assertions.sv
`timescale 1ns/1ps

// Watches the flash control ports for erase and store ordering faults.
module erase_ctl_assertions (
	// Clock, reset and register writes.
	input wire logic        core_clk_i,
	input wire logic        resetn_i,
	input wire logic        sfr_wr_i,
	input wire logic [7:0]  sfr_addr_i,
	input wire logic [7:0]  sfr_wdata_i,
	input wire logic        ice_enable_i,
	// Store path and flash array.
	input wire logic        xstore_i,
	input wire logic [15:0] xstore_addr_i,
	input wire logic [7:0]  xstore_data_i,
	input wire logic        flash_wr_o,
	input wire logic [15:0] flash_addr_o,
	input wire logic [7:0]  flash_wdata_o,
	input wire logic        ram_wr_o,
	input wire logic [15:0] ram_addr_o,
	input wire logic [7:0]  ram_wdata_o,
	input wire logic        page_erase_o,
	input wire logic        mass_erase_o,
	input wire logic        erase_busy_o,
	input wire logic        flash_array_erased_i,
	input wire logic [7:0]  flash_rdata_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	mass_key_a: assert property (
		$rose(mass_erase_o) |-> $past(ice_enable_i && sfr_wr_i && sfr_addr_i == 8'h94
		&& sfr_wdata_i == 8'haa)) else $error("Mass erase began without its key.");
	page_key_a: assert property (
		$rose(page_erase_o) |-> $past(sfr_wr_i && sfr_addr_i == 8'h94 && sfr_wdata_i == 8'h55))
		else $error("Page erase began without its key.");
	erase_hold_a: assert property ($rose(page_erase_o) |=> page_erase_o[*8])
		else $error("Page erase ended too soon.");
	erase_busy_a: assert property ((page_erase_o || mass_erase_o) |-> erase_busy_o
		&& !(page_erase_o && mass_erase_o)) else $error("Erase status is inconsistent.");
	store_taken_a: assert property (xstore_i |=> flash_wr_o || ram_wr_o)
		else $error("Store was lost.");
	store_flash_a: assert property (flash_wr_o |-> $past(xstore_i)
		&& flash_addr_o == $past(xstore_addr_i) && flash_wdata_o == $past(xstore_data_i))
		else $error("Flash write does not match the store.");
	store_ram_a: assert property (ram_wr_o |-> $past(xstore_i)
		&& ram_addr_o == $past(xstore_addr_i) && ram_wdata_o == $past(xstore_data_i))
		else $error("RAM write does not match the store.");
	alias_ram_a: assert property (flash_wr_o && flash_addr_o[15:11] == 5'h00 |-> ram_wr_o)
		else $error("Aliased RAM cell was not written.");
	erased_read_a: assert property (flash_array_erased_i |=> flash_rdata_o == 8'hff)
		else $error("Erased byte did not read as all ones.");
endmodule

//--- test_flash_erase_write_control.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end

module test_flash_erase_write_control;
	import flash_ctl_pkg::*;
	// Stimulus and observed signals.
	logic        clk = 0, rst_n = 0, wr = 0, rd = 0, ice = 0, xs = 0, erased = 0;
	logic [7:0]  addr = 0, wd = 0, xd = 0, adat = 0, rdata, frd, fwd, rwd;
	logic [15:0] xa = 0, fa, ra;
	logic [6:0]  pg;
	logic        fwr, rwr, pe, me, busy, pws;
	int          bad_count = 0;
	int          n_checks = 0;

	flash_erase_write_control DUT (.core_clk_i(clk), .resetn_i(rst_n), .sfr_wr_i(wr),
		.sfr_rd_i(rd), .sfr_addr_i(addr), .sfr_wdata_i(wd), .sfr_rdata_o(rdata),
		.ice_enable_i(ice), .xstore_i(xs), .xstore_addr_i(xa), .xstore_data_i(xd),
		.flash_wr_o(fwr), .flash_addr_o(fa), .flash_wdata_o(fwd), .page_erase_o(pe),
		.mass_erase_o(me), .erase_page_o(pg), .erase_busy_o(busy),
		.flash_pulse_width_sel_o(pws), .flash_array_rdata_i(adat),
		.flash_array_erased_i(erased), .flash_rdata_o(frd), .ram_wr_o(rwr),
		.ram_addr_o(ra), .ram_wdata_o(rwd));

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Bus helpers; each register access and store leaves an idle cycle so strobes never toggle twice in one step.
	task automatic step; @(posedge clk); #1; endtask
	task automatic wr_reg(input logic [7:0] a, d);
		addr = a; wd = d; wr = 1; step; wr = 0; step;
	endtask
	task automatic rd_reg(input logic [7:0] a, e, input string n);
		addr = a; rd = 1; step; rd = 0; `CHK(n, e, rdata) step;
	endtask
	task automatic store(input logic [15:0] a, input logic ef, er);
		xa = a; xd = a[7:0] ^ 8'h5a; xs = 1; step; xs = 0;
		`CHK("flash_wr", ef, fwr) `CHK("ram_wr", er, rwr)
		if (ef) `CHK("flash_addr", a, fa)
		if (ef) `CHK("flash_data", a[7:0] ^ 8'h5a, fwd)
		if (er) `CHK("ram_addr", a, ra)
		if (er) `CHK("ram_data", a[7:0] ^ 8'h5a, rwd)
		step;
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 5000 && busy !== 1'b0; i++) step;
		if (busy !== 1'b0) begin bad_count++; report_and_stop; end
	endtask

	// Clock of 50 ns period.
	initial
	begin
		forever #25 clk = ~clk;
	end

	// Main sequence.
	initial
	begin
		repeat (12) @(posedge clk);
		#1 rst_n = 1;
		rd_reg(8'hb2, 8'h00, "ctrl_rst"); rd_reg(8'hb7, 8'h00, "page_rst");
		rd_reg(8'h94, 8'h00, "trig_read"); rd_reg(8'h33, 8'h00, "unmapped");
		wr_reg(8'hb2, 8'hff); rd_reg(8'hb2, 8'h07, "ctrl_rw");
		`CHK("pulse_sel", 1'b1, pws)
		wr_reg(8'hb2, 8'h00); `CHK("pulse_sel", 1'b0, pws)
		wr_reg(8'h94, 8'haa); `CHK("busy", 1'b0, busy)
		wr_reg(8'h94, 8'hab); `CHK("busy", 1'b0, busy)
		wr_reg(8'hb2, 8'h02); wr_reg(8'h94, 8'haa); `CHK("busy", 1'b0, busy)
		ice = 1; wr_reg(8'h94, 8'haa); `CHK("mass", 1'b1, me)
		wr_reg(8'h94, 8'h55); `CHK("page", 1'b0, pe)
		wait_idle; `CHK("mass_end", 1'b0, me)
		rd_reg(8'hb2, 8'h00, "enable_clear");
		wr_reg(8'hb7, 8'h2b); rd_reg(8'hb7, 8'h2a, "page_sel");
		wr_reg(8'h94, 8'h55); `CHK("page", 1'b1, pe) `CHK("page_no", 7'h15, pg)
		// No interrupt source exists in the bench, so interrupts stay off with write enable set.
		wr_reg(8'hb2, 8'h01); store(16'h8000, 0, 1);
		wait_idle; `CHK("page_end", 1'b0, pe)
		store(16'h0010, 1, 1); store(16'h8000, 1, 0);
		// Stores keep clear of the configuration cells 0x2000 to 0x2007.
		store(16'h1200, 1, 1); store(16'h20ff, 1, 1); store(16'h3fff, 1, 1);
		wr_reg(8'hb2, 8'h00); store(16'h8000, 0, 1);
		erased = 1; step; `CHK("erased", 8'hff, frd)
		erased = 0; adat = 8'h3c; step; `CHK("rdata", 8'h3c, frd)
		report_and_stop;
	end
endmodule

bind flash_erase_write_control erase_ctl_assertions chk (.*);
